// ### sim/pin_partner.sv
// Behavioural party on the unit pin: a signal source and a load.
// Assumes the bench clock; the bench sets the level and clears the count.
`timescale 1ns/1ps
`default_nettype none

module pin_partner
(
   // Clock and bench control.
   input  wire logic        clock_in,
   input  wire logic        level_in,
   input  wire logic        count_clear_in,
   // Pin side.
   input  wire logic        load_in,
   output logic             pin_out,
   output logic [15:0]      high_count_out
);
   // The source follows the request; the load counts the cycles the pin is high.
   always_ff @(posedge clock_in)
   begin
      pin_out        <= level_in;
      high_count_out <= count_clear_in ? 16'h0000 : high_count_out + {15'h0000, load_in};
   end
endmodule

`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the capture, compare and PWM unit.
// Assumes the unit and the pin partner share one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_map.svh"

module testbench;
   logic        clock_in, rstn_in, psel, pen, pwr, lvl, clr, run, err;
   logic        t1_rst, ovf_set, adc_go, pin_in, pin_out, flag, rdy, slverr, upd;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, rd;
   logic [15:0] t1, t1_set, highs;
   logic [3:0]  cmp_mode [3] = '{4'h9, 4'h8, 4'ha};
   logic [2:0]  cmp_pin = 3'b110;
   int          tab [4][5] = '{'{8'h0c, 8'h04, 8'h00, 160, 0}, '{8'h0c, 8'h04, 8'h01, 160, 40},
                               '{8'h0c, 8'h04, 8'hff, 160, 160}, '{8'h2c, 8'h7d, 8'h01, 640, 240}};
   int          failures, num_checks, i, ups;

   capture_compare_pwm_unit #(.SECOND_UNIT(1'b0), .SMALLEST_MEMBER(1'b1)) DUT
      (.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(pen),
       .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdata), .prdata_out(rdata),
       .pready_out(rdy), .pslverr_out(slverr), .timer1_count_in(t1),
       .timer1_overflow_in(1'b1), .adc_enable_in(1'b1), .timer1_reset_out(t1_rst),
       .timer1_overflow_set_out(ovf_set), .adc_start_out(adc_go), .timer2_update_out(upd),
       .unit_pin_in(pin_in), .unit_pin_out(pin_out), .unit_event_flag_out(flag));
   pin_partner partner (.clock_in(clock_in), .level_in(lvl), .count_clear_in(clr),
                        .load_in(pin_out), .pin_out(pin_in), .high_count_out(highs));

   // Compares a seen value with the expected one and counts both.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim;
      $display("Checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel  <= 1'b1;
      pwr   <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clock_in);
      pen <= 1'b1;
      do
      begin
         @(posedge clock_in);
         n++;
      end
      while (rdy !== 1'b1 && n < 20);
      rd  = rdata;
      err = slverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (rdy !== 1'b1)
      begin
         failures++;
         end_sim();
      end
      @(posedge clock_in);
   endtask

   // Waits a bounded time for the event flag.
   task automatic wait_flag;
      int n;
      n = 0;
      while (flag !== 1'b1 && n < 600)
      begin
         @(posedge clock_in);
         n++;
      end
      check(flag, 1'b1);
      if (flag !== 1'b1)
         end_sim();
   endtask

   // Sends rising edges on the pin, four clocks high and four low.
   task automatic pulses(input int k);
      repeat (k)
      begin
         lvl <= 1'b1;
         repeat (4) @(posedge clock_in);
         lvl <= 1'b0;
         repeat (4) @(posedge clock_in);
      end
      repeat (4) @(posedge clock_in);
   endtask

   // Timer1 stand-in: a synchronous count wrapping at 8'hff, cleared by the special event.
   // While stopped it holds the preset that the scenario asks for.
   always @(posedge clock_in)
      if (run && (t1_rst === 1'b1 || t1 >= 16'h00ff))
         t1 <= 16'h0000;
      else if (run)
         t1 <= t1 + 16'h0001;
      else
         t1 <= t1_set;

   // Counts Timer2 update pulses over the same window as the load.
   always @(posedge clock_in)
      ups <= clr ? 0 : ups + int'(upd);

   // A special event starts a conversion and never raises the overflow flag.
   always @(posedge clock_in)
      if (t1_rst === 1'b1)
         check({30'h0, ovf_set, adc_go}, 32'h1);

   // Free-running clock.
   initial
   begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end

   // Reset, then capture, compare, special event and PWM in turn.
   initial
   begin
      {rstn_in, psel, pen, pwr, lvl, clr, run, err} = 8'h00;
      {addr, wdata, t1_set} = 56'h0;
      repeat (20) @(posedge clock_in);
      rstn_in <= 1'b1;
      @(posedge clock_in);
      apb(1'b0, `ADDR_MODE, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, `ADDR_PERIOD, 32'h0);
      check(rd, 32'hff);
      apb(1'b0, 8'h1c, 32'h0);
      check({rd[30:0], err}, 32'h1);
      t1_set <= 16'h1234;
      apb(1'b1, `ADDR_MODE, 32'h06);
      pulses(2);
      apb(1'b1, `ADDR_MODE, 32'h00);
      apb(1'b1, `ADDR_MODE, 32'h06);
      apb(1'b1, `ADDR_STATUS, 32'h1);
      pulses(3);
      check(flag, 1'b0);
      pulses(1);
      check(flag, 1'b1);
      apb(1'b0, `ADDR_VALUE_HI, 32'h0);
      check(rd, 32'h12);
      apb(1'b0, `ADDR_VALUE_LO, 32'h0);
      check(rd, 32'h34);
      apb(1'b1, `ADDR_MODE, 32'h0);
      apb(1'b1, `ADDR_STATUS, 32'h1);
      run <= 1'b1;
      apb(1'b1, `ADDR_VALUE_LO, 32'h40);
      apb(1'b1, `ADDR_VALUE_HI, 32'h0);
      for (i = 0; i < 3; i++)
      begin
         apb(1'b1, `ADDR_MODE, {28'h0, cmp_mode[i]});
         wait_flag();
         check(pin_out, cmp_pin[i]);
         apb(1'b1, `ADDR_STATUS, 32'h1);
      end
      apb(1'b1, `ADDR_MODE, 32'h0);
      check(pin_out, 1'b0);
      apb(1'b1, `ADDR_VALUE_LO, 32'h20);
      apb(1'b1, `ADDR_MODE, 32'h0b);
      wait_flag();
      repeat (300) @(posedge clock_in);
      check(t1 < 16'h0024, 1'b1);
      apb(1'b1, `ADDR_MODE, 32'h0);
      apb(1'b1, `ADDR_PERIOD, 32'h3);
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, `ADDR_VALUE_LO, tab[i][2]);
         apb(1'b1, `ADDR_T2_CTRL, tab[i][1]);
         apb(1'b1, `ADDR_MODE, tab[i][0]);
         repeat (128) @(posedge clock_in);
         clr <= 1'b1;
         @(posedge clock_in);
         clr <= 1'b0;
         repeat (tab[i][3] + 1) @(posedge clock_in);
         check(highs, tab[i][4]);
         if (i < 3)
            check(ups, 32'h0000_000a);
      end
      apb(1'b1, `ADDR_VALUE_HI, 32'h55);
      apb(1'b0, `ADDR_VALUE_HI, 32'h0);
      check(rd, 32'h1);
      end_sim();
   end
endmodule

`default_nettype wire

// ### src/capture_compare_map.svh
// Register offsets, field positions, reset values and counts for the unit.
// Assumes byte addresses on an APB bus with one 32-bit word per register.
`ifndef CAPTURE_COMPARE_MAP_SVH
`define CAPTURE_COMPARE_MAP_SVH

// Register byte offsets.
`define ADDR_MODE      8'h00
`define ADDR_VALUE_LO  8'h04
`define ADDR_VALUE_HI  8'h08
`define ADDR_STATUS    8'h0c
`define ADDR_T2_CTRL   8'h10
`define ADDR_PERIOD    8'h14
`define ADDR_T2_COUNT  8'h18

// Reset values.
`define MODE_RST       6'h00
`define T2_CTRL_RST    7'h00
`define PERIOD_RST     8'hff
`define BYTE_RST       8'h00

// Mode control fields.
`define MODE_W         6
`define MODE_HI        3
`define MODE_LO        0
`define CLASS_HI       3
`define CLASS_LO       2
`define DUTY_HI        5
`define DUTY_LO        4
`define CLASS_CAPTURE  2'h1
`define CLASS_COMPARE  2'h2
`define CLASS_PWM      2'h3

// Status and Timer2 control fields.
`define STATUS_FLAG    0
`define T2_CTRL_W      7
`define T2_ON          2
`define T2_PS_HI       1
`define T2_PS_LO       0
`define T2_POST_HI     6
`define T2_POST_LO     3

// Prescaler terminal counts.
`define Q_LAST         2'h3
`define PS1_LAST       4'h0
`define PS4_LAST       4'h3
`define PS16_LAST      4'hf

`endif

// ### src/capture_compare_pkg.sv
// Types shared by the capture, compare and PWM unit.
// Assumes the map header supplies all numeric offsets and fields.
package capture_compare_pkg;

   // Mode field encodings; codes 0001 to 0011 are unused.
   typedef enum logic [3:0]
   {
      MODE_OFF       = 4'h0,
      MODE_CAP_FALL  = 4'h4,
      MODE_CAP_RISE  = 4'h5,
      MODE_CAP_4TH   = 4'h6,
      MODE_CAP_16TH  = 4'h7,
      MODE_CMP_SET   = 4'h8,
      MODE_CMP_CLEAR = 4'h9,
      MODE_CMP_SOFT  = 4'ha,
      MODE_CMP_TRIG  = 4'hb
   } unit_mode_e;

endpackage

// ### src/capture_compare_pwm_unit.sv
// Capture, compare and PWM unit with its registers on an APB slave port.
// Assumes Timer1 and the A/D converter sit outside on the same clock.
//
// Contract
// - Capture prescaler counter is cleared whenever the unit is not capturing.
// - Switching between capture prescales keeps the partly filled counter.
// - Compare mode matches value with Timer1, acts on pin, sets flag.
// - Writing zero to mode control forces the compare latch low.
// - Software-interrupt compare leaves pin alone and only sets the flag.
// - Special event on the first unit resets Timer1, a programmable period.
// - Second unit's special event resets Timer1 and starts A/D when enabled.
// - Smallest member: first unit's special event also starts A/D conversion.
// - Special event Timer1 reset never sets the Timer1 overflow flag.
// - Writing zero to mode control forces the PWM latch low.
// - At period match Timer2 clears, pin sets unless 0%, duty reloads.
// - Timer2 postscaler never affects the PWM period.
// - Duty is ten bits: low byte above mode control bits 5:4.
// - Duty takes effect at next period match; high byte read-only in PWM.
// - Buffered duty against Timer2 plus two fine bits clears the pin.
// - Duty beyond the period never clears the pin, giving 100% high.
// - Mode field encodes off, four capture, four compare, and PWM modes.
// - Capture copies Timer1 into the value register and sets the flag.
// - Timer2 prescale field maps 00 to 1, 01 to 4, 1x to 16.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_map.svh"

module capture_compare_pwm_unit
#(
   parameter bit SECOND_UNIT     = 1'b0,
   parameter bit SMALLEST_MEMBER = 1'b0
)
(
   // Clock and reset.
   input  wire logic        clock_in,
   input  wire logic        rstn_in,
   // APB slave port.
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Timer1, Timer2 and A/D hooks.
   input  wire logic [15:0] timer1_count_in,
   input  wire logic        timer1_overflow_in,
   input  wire logic        adc_enable_in,
   output logic             timer1_reset_out,
   output logic             timer1_overflow_set_out,
   output logic             adc_start_out,
   output logic             timer2_update_out,
   // Pin and event.
   input  wire logic        unit_pin_in,
   output logic             unit_pin_out,
   output logic             unit_event_flag_out
);

   // ****************************************************************
   // Declarations
   // ****************************************************************

   logic [5:0]  unit_mode_control;
   logic [7:0]  duty_low_byte;
   logic [7:0]  value_high_byte;
   logic [1:0]  duty_fine_latch;
   logic        unit_event_flag;
   logic [6:0]  timer2_control;
   logic [7:0]  pwm_period_limit;
   logic        pin_latch;
   logic        match_seen;
   logic        pwm_set_due;

   logic        setup_phase;
   logic        access_phase;
   logic        wr;
   logic        hit_mode;
   logic        hit_vlo;
   logic        hit_vhi;
   logic        hit_status;
   logic        hit_t2ctrl;
   logic        hit_period;
   logic        hit_t2count;
   logic        addr_hit;
   logic        wr_mode;
   logic        wr_mode_zero;
   logic [31:0] read_mux;

   logic [3:0]  mode_field;
   logic        mode_off;
   logic        cap_mode;
   logic        cmp_mode;
   logic        pwm_mode;
   logic        t1_match;
   logic        match_rise;
   logic        trigger;
   logic        cap_take;
   logic        event_set;
   logic        status_clear;
   logic [9:0]  duty_next;
   logic        pwm_load;
   logic        pwm_clear;
   logic        next_pin_latch;

   unit_link_if link ();

   // ****************************************************************
   // Submodules
   // ****************************************************************

   // Timer2 time base for PWM.
   timer2_base u_timer2
   (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .link     (link.timer_side)
   );

   // Pin synchroniser and capture prescaler.
   capture_edge_detect u_capture
   (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .link     (link.capture_side)
   );

   // ****************************************************************
   // APB decode
   // ****************************************************************

   // Phase, address and write decode.
   assign setup_phase  = psel_in & ~penable_in;
   assign access_phase = psel_in & penable_in;
   assign wr           = access_phase & pwrite_in;
   assign hit_mode     = paddr_in == `ADDR_MODE;
   assign hit_vlo      = paddr_in == `ADDR_VALUE_LO;
   assign hit_vhi      = paddr_in == `ADDR_VALUE_HI;
   assign hit_status   = paddr_in == `ADDR_STATUS;
   assign hit_t2ctrl   = paddr_in == `ADDR_T2_CTRL;
   assign hit_period   = paddr_in == `ADDR_PERIOD;
   assign hit_t2count  = paddr_in == `ADDR_T2_COUNT;
   assign addr_hit     = hit_mode | hit_vlo | hit_vhi | hit_status |
                         hit_t2ctrl | hit_period | hit_t2count;
   assign wr_mode      = wr & hit_mode;
   assign wr_mode_zero = wr_mode &
                         (pwdata_in[`MODE_HI:`MODE_LO] == capture_compare_pkg::MODE_OFF);

   // Zero wait states; an unmapped address answers with an error.
   assign pready_out  = 1'b1;
   assign pslverr_out = access_phase & ~addr_hit;

   // Read selection; upper bits read as zero.
   assign read_mux =
      hit_mode    ? 32'(unit_mode_control) :
      hit_vlo     ? 32'(duty_low_byte) :
      hit_vhi     ? 32'(value_high_byte) :
      hit_status  ? 32'(unit_event_flag) :
      hit_t2ctrl  ? 32'(timer2_control) :
      hit_period  ? 32'(pwm_period_limit) :
      hit_t2count ? 32'(link.t2_count) :
      32'h0000_0000;

   // ****************************************************************
   // Mode and event decode
   // ****************************************************************

   // Mode classes.
   assign mode_field = unit_mode_control[`MODE_HI:`MODE_LO];
   assign mode_off   = mode_field == capture_compare_pkg::MODE_OFF;
   assign cap_mode   = mode_field[`CLASS_HI:`CLASS_LO] == `CLASS_CAPTURE;
   assign cmp_mode   = mode_field[`CLASS_HI:`CLASS_LO] == `CLASS_COMPARE;
   assign pwm_mode   = mode_field[`CLASS_HI:`CLASS_LO] == `CLASS_PWM;

   // Compare acts once per entry into equality, not every cycle it lasts.
   assign t1_match   = {value_high_byte, duty_low_byte} == timer1_count_in;
   assign match_rise = cmp_mode & t1_match & ~match_seen;
   assign trigger    = match_rise & (mode_field == capture_compare_pkg::MODE_CMP_TRIG);

   // Capture and flag events; a set beats a clear in the same cycle.
   assign cap_take     = cap_mode & link.cap_event;
   assign event_set    = cap_take | match_rise;
   assign status_clear = wr & hit_status & pwdata_in[`STATUS_FLAG];

   // PWM duty assembly and pin decisions.
   assign duty_next = {duty_low_byte, unit_mode_control[`DUTY_HI:`DUTY_LO]};
   assign pwm_load  = pwm_mode & link.t2_rollover;
   // A duty beyond the period never meets the count, so the pin stays high.
   assign pwm_clear = pwm_mode &
      ({value_high_byte, duty_fine_latch} == {link.t2_count, link.t2_fine});

   // Pin latch next value, highest priority first.
   // The PWM set lands one cycle after the reload, so it lags like the clear does.
   assign next_pin_latch =
      wr_mode_zero ? 1'b0 :
      mode_off     ? 1'b0 :
      (pwm_mode && pwm_set_due) ? 1'b1 :
      pwm_clear    ? 1'b0 :
      (match_rise && mode_field == capture_compare_pkg::MODE_CMP_SET)   ? 1'b1 :
      (match_rise && mode_field == capture_compare_pkg::MODE_CMP_CLEAR) ? 1'b0 :
      pin_latch;

   // Link wiring.
   assign link.t2_ctrl     = timer2_control;
   assign link.t2_period   = pwm_period_limit;
   assign link.t2_wr_count = wr & hit_t2count;
   assign link.t2_wr_ctrl  = wr & hit_t2ctrl;
   assign link.t2_wr_data  = pwdata_in[7:0];
   assign link.cap_mode    = mode_field;
   assign link.cap_pin     = unit_pin_in;

   // Outputs straight from state.
   assign unit_pin_out        = pin_latch;
   assign unit_event_flag_out = unit_event_flag;
   assign timer2_update_out   = link.t2_update;
   // Special resets are not overflows and must not raise the overflow flag.
   assign timer1_overflow_set_out = timer1_overflow_in & ~trigger & ~timer1_reset_out;

   // ****************************************************************
   // Registers
   // ****************************************************************

   // Mode control.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         unit_mode_control <= `MODE_RST;
      else if (wr_mode)
         unit_mode_control <= pwdata_in[`MODE_W-1:0];
   end

   // Value low byte: captured count or duty upper bits.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         duty_low_byte <= `BYTE_RST;
      else if (cap_take)
         duty_low_byte <= timer1_count_in[7:0];
      else if (wr && hit_vlo)
         duty_low_byte <= pwdata_in[7:0];
   end

   // Value high byte: captured count, reloaded duty, or software data.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         value_high_byte <= `BYTE_RST;
      else if (cap_take)
         value_high_byte <= timer1_count_in[15:8];
      else if (pwm_load)
         value_high_byte <= duty_low_byte;
      else if (wr && hit_vhi && !pwm_mode)
         value_high_byte <= pwdata_in[7:0];
   end

   // Hidden two-bit duty latch.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         duty_fine_latch <= 2'h0;
      else if (pwm_load)
         duty_fine_latch <= unit_mode_control[`DUTY_HI:`DUTY_LO];
   end

   // Event flag, cleared by writing one.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         unit_event_flag <= 1'b0;
      else if (event_set)
         unit_event_flag <= 1'b1;
      else if (status_clear)
         unit_event_flag <= 1'b0;
   end

   // Timer2 control and period limit.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         timer2_control   <= `T2_CTRL_RST;
         pwm_period_limit <= `PERIOD_RST;
      end
      else
      begin
         if (wr && hit_t2ctrl)
            timer2_control <= pwdata_in[`T2_CTRL_W-1:0];
         if (wr && hit_period)
            pwm_period_limit <= pwdata_in[7:0];
      end
   end

   // Pin latch and match history.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pin_latch  <= 1'b0;
         match_seen <= 1'b0;
         pwm_set_due <= 1'b0;
      end
      else
      begin
         pin_latch  <= next_pin_latch;
         match_seen <= cmp_mode & t1_match;
         pwm_set_due <= pwm_load & (duty_next != 10'h000);
      end
   end

   // Special event pulses toward Timer1 and the A/D converter.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         timer1_reset_out <= 1'b0;
         adc_start_out    <= 1'b0;
      end
      else
      begin
         timer1_reset_out <= trigger;
         adc_start_out    <= trigger & adc_enable_in &
                             (SECOND_UNIT | SMALLEST_MEMBER);
      end
   end

   // Read data is caught in the setup phase and held for the access phase.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
         prdata_out <= 32'h0000_0000;
      else if (setup_phase)
         prdata_out <= read_mux;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rstn_in);

   sequence mode_zero_write;
      wr_mode_zero;
   endsequence

   sequence compare_hit(logic [3:0] code);
      match_rise && mode_field == code && !wr_mode;
   endsequence

   chk_zero_forces_low : assert property (mode_zero_write |=> !unit_pin_out)
      else $error("Zero mode write left the pin latch high.");

   chk_cmp_set_pin : assert property (
      compare_hit(capture_compare_pkg::MODE_CMP_SET) |=> unit_pin_out && unit_event_flag)
      else $error("Set-on-match did not drive the pin high.");

   chk_cmp_clear_pin : assert property (
      compare_hit(capture_compare_pkg::MODE_CMP_CLEAR) |=> !unit_pin_out)
      else $error("Clear-on-match did not drive the pin low.");

   chk_soft_int_pin : assert property (
      compare_hit(capture_compare_pkg::MODE_CMP_SOFT) |=> $stable(unit_pin_out) && unit_event_flag)
      else $error("Software-interrupt match touched the pin.");

   chk_trigger_reset : assert property (trigger |=> timer1_reset_out ##1 !timer1_reset_out)
      else $error("Special event did not pulse the Timer1 reset.");

   chk_no_overflow : assert property (timer1_reset_out |-> !timer1_overflow_set_out)
      else $error("Special reset raised the overflow flag.");

   chk_capture_copy : assert property (cap_take |=>
      {value_high_byte, duty_low_byte} == $past(timer1_count_in) && unit_event_flag)
      else $error("Capture did not copy Timer1 or set the flag.");

   chk_pwm_reload : assert property (pwm_load && !wr_mode ##1 !wr_mode |->
      value_high_byte == $past(duty_low_byte) ##1
      unit_pin_out == ($past(duty_next, 2) != 10'h000))
      else $error("Period match did not reload duty and set the pin.");

   chk_pwm_high_held : assert property (pwm_mode && !pwm_load && !wr_mode &&
      value_high_byte > pwm_period_limit && unit_pin_out |=> unit_pin_out)
      else $error("Duty beyond period cleared the pin.");

endmodule

`default_nettype wire

// ### src/capture_edge_detect.sv
// Pin synchroniser, edge detector and capture event prescaler.
// Assumes the pin is asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_map.svh"

module capture_edge_detect
(
   // Clock and reset.
   input  wire logic         clock_in,
   input  wire logic         rstn_in,
   // Link to the core.
   unit_link_if.capture_side link
);

   logic       sync_a;
   logic       sync_b;
   logic       prev;
   logic [3:0] edges;
   logic       rise;
   logic       fall;
   logic       is_capture;

   // Edge decode on the second synchroniser stage.
   assign rise       = sync_b & ~prev;
   assign fall       = ~sync_b & prev;
   assign is_capture = link.cap_mode[`CLASS_HI:`CLASS_LO] == `CLASS_CAPTURE;
   assign link.cap_event = is_capture &
      ((link.cap_mode == capture_compare_pkg::MODE_CAP_FALL) ? fall :
       (link.cap_mode == capture_compare_pkg::MODE_CAP_RISE) ? rise :
       (link.cap_mode == capture_compare_pkg::MODE_CAP_4TH)  ? rise & (edges[1:0] == 2'(`PS4_LAST)) :
       rise & (edges == `PS16_LAST));

   // Synchroniser and rising-edge counter; switching between capture modes keeps it.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev   <= 1'b0;
         edges  <= 4'h0;
      end
      else
      begin
         sync_a <= link.cap_pin;
         sync_b <= sync_a;
         prev   <= sync_b;
         if (!is_capture)
            edges <= 4'h0;
         else if (rise)
            edges <= 4'(edges + 4'h1);
      end
   end

   chk_presc_cleared : assert property (@(posedge clock_in) disable iff (!rstn_in)
      !is_capture |=> edges == 4'h0)
      else $error("Capture prescaler not cleared outside capture.");

endmodule

`default_nettype wire

// ### src/timer2_base.sv
// Timer2 time base: quarter clock, 1/4/16 prescaler, period match, postscaler.
// Assumes the core clock is the oscillator clock, four per instruction cycle.
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_map.svh"

module timer2_base
(
   // Clock and reset.
   input  wire logic       clock_in,
   input  wire logic       rstn_in,
   // Link to the core.
   unit_link_if.timer_side link
);

   logic [1:0] quarter;
   logic [3:0] presc;
   logic [3:0] post;
   logic [7:0] count;
   logic       running;
   logic [1:0] ps_sel;
   logic [3:0] post_sel;
   logic [3:0] presc_last;
   logic       presc_done;
   logic       inc;
   logic       clear_ps;

   // Prescaler decode, increment and period match.
   assign running    = link.t2_ctrl[`T2_ON];
   assign ps_sel     = link.t2_ctrl[`T2_PS_HI:`T2_PS_LO];
   assign post_sel   = link.t2_ctrl[`T2_POST_HI:`T2_POST_LO];
   assign presc_last = ps_sel[1] ? `PS16_LAST : (ps_sel[0] ? `PS4_LAST : `PS1_LAST);
   assign presc_done = presc == presc_last;
   assign inc        = running & (quarter == `Q_LAST) & presc_done;
   assign clear_ps   = link.t2_wr_ctrl | link.t2_wr_count;
   assign link.t2_rollover = inc & (count == link.t2_period);
   // Fine bits extend the count: quarter clock, or prescaler bits 1:0 at 1/4 and bits 3:2 at 1/16.
   assign link.t2_fine = ps_sel[1] ? presc[3:2] : (ps_sel[0] ? presc[1:0] : quarter);
   // The postscaler only paces updates and never touches the period.
   assign link.t2_update = link.t2_rollover & (post == post_sel);
   assign link.t2_count  = count;

   // Quarter clock and prescaler.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         quarter <= 2'h0;
         presc   <= 4'h0;
      end
      else
      begin
         quarter <= 2'(quarter + 2'h1);
         if (clear_ps)
            presc <= 4'h0;
         else if (running && quarter == `Q_LAST)
            presc <= presc_done ? 4'h0 : 4'(presc + 4'h1);
      end
   end

   // Count and postscaler.
   always_ff @(posedge clock_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         count <= `BYTE_RST;
         post  <= 4'h0;
      end
      else
      begin
         if (link.t2_wr_count)
            count <= link.t2_wr_data;
         else if (link.t2_rollover)
            count <= `BYTE_RST;
         else if (inc)
            count <= 8'(count + 8'h01);
         if (clear_ps)
            post <= 4'h0;
         else if (link.t2_rollover)
            post <= (post == post_sel) ? 4'h0 : 4'(post + 4'h1);
      end
   end

   chk_t2_period_clear : assert property (@(posedge clock_in) disable iff (!rstn_in)
      link.t2_rollover && !link.t2_wr_count |=> link.t2_count == 8'h00)
      else $error("Timer2 not cleared after period match.");

endmodule

`default_nettype wire

// ### src/unit_link_if.sv
// Signals between the unit core, its Timer2 time base and its edge detector.
// Assumes all three parties share one clock.
`timescale 1ns/1ps
`default_nettype none

interface unit_link_if;
   logic [6:0] t2_ctrl;
   logic [7:0] t2_period;
   logic       t2_wr_count;
   logic       t2_wr_ctrl;
   logic [7:0] t2_wr_data;
   logic [7:0] t2_count;
   logic [1:0] t2_fine;
   logic       t2_rollover;
   logic       t2_update;
   logic [3:0] cap_mode;
   logic       cap_pin;
   logic       cap_event;

   modport timer_side (input t2_ctrl, t2_period, t2_wr_count, t2_wr_ctrl, t2_wr_data,
                       output t2_count, t2_fine, t2_rollover, t2_update);
   modport capture_side (input cap_mode, cap_pin, output cap_event);
endinterface

`default_nettype wire
